// >>> swr_acq_model.sv
// Acquisition data path model: holds the word being stored into memory.
// Assumes the bench requests a new word with a one-cycle load pulse.
`default_nettype none
module swr_acq_model (
    input  wire logic        core_clk,
    input  wire logic        load,
    input  wire logic [23:0] word_in,
    output var  logic [23:0] acquired_word
);
    timeunit 1ns;
    timeprecision 1ns;
    // Word stays steady between loads, as a stored sample would
    initial acquired_word = 24'h000000;
    // New word on the load edge; byte slices feed the three RAM pairs
    always @(posedge core_clk) begin
        if (load) begin
            acquired_word <= word_in;
        end
    end
endmodule
`default_nettype wire

// >>> swr_pkg.sv
// Package for the sequential word recognizer: port map, fields, resets.
// Assumes a single 25 MHz clock domain and a byte-wide local bus.
`default_nettype none
package swr_pkg;
    // Register port offsets
    localparam logic [7:0] PTR_RDBK_OFS   = 8'h04; // Pointer readback
    localparam logic [7:0] SEQ_WE_A_OFS   = 8'h04; // Seq RAM A write
    localparam logic [7:0] SEQ_WE_B_OFS   = 8'h05; // Seq RAM B write
    localparam logic [7:0] SEQ_WE_C_OFS   = 8'h06; // Seq RAM C write
    localparam logic [7:0] QUAL_RDBK_OFS  = 8'h07; // Qualifier readback
    localparam logic [7:0] SEQ_RDBK_OFS   = 8'h0e; // Seq RAM readback
    localparam logic [7:0] MODE_OFS       = 8'h10; // Load select, bit 4
    localparam logic [7:0] GATE_OFS       = 8'h11; // Clock gate, bit 0
    localparam logic [7:0] STEP_OFS       = 8'h12; // Pointer step strobe
    localparam logic [7:0] CTRL_WR_OFS    = 8'h13; // Control RAM write
    localparam logic [7:0] CTRL_RD_OFS    = 8'h14; // Control RAM read
    localparam logic [7:0] QUAL_WR_A_OFS  = 8'h15; // Qualifier RAM A
    localparam logic [7:0] QUAL_WR_B_OFS  = 8'h16; // Qualifier RAM B
    localparam logic [7:0] QUAL_WR_C_OFS  = 8'h17; // Qualifier RAM C
    localparam logic [7:0] QUAL_SEL_OFS   = 8'h18; // Qualifier read select
    localparam logic [7:0] IRQ_STAT_OFS   = 8'h19; // Sticky events
    localparam logic [7:0] IRQ_MASK_OFS   = 8'h1a; // Event mask
    // Field positions
    localparam int        LOAD_SEL_BIT    = 4;     // Mode byte bit
    localparam int        PTR_RDBK_LSB    = 2;     // Pointer in bits 5:2
    localparam int        SEQ_RDBK_LSB    = 5;     // Matches in bits 7:5
    // Reset values
    localparam logic       LOAD_SEL_RST   = 1'b0;  // Load mode
    localparam logic       GATE_N_RST     = 1'b1;  // Strobes blocked
    localparam logic [3:0] PTR_RST        = 4'h0;
    localparam logic [1:0] IRQ_MASK_RST   = 2'h0;
    // Sizes
    localparam int        LEVELS          = 16;
    localparam int        SEQ_DEPTH       = 4096;
    localparam int        QUAL_DEPTH      = 256;
    // Bus request carrier
    typedef struct packed {
        logic [7:0] addr; // Port address
        logic [7:0] wdata; // Write data
        logic       wr;   // Write strobe
        logic       rd;   // Read strobe
    } swr_bus_t;
    // Match results carrier
    typedef struct packed {
        logic       level; // Sequence level match
        logic [3:0] qual;  // Qualifier matches
    } swr_match_t;
    // Pointer modes
    typedef enum logic {
        SWR_LOAD,
        SWR_COUNT
    } swr_mode_t;
endpackage
`default_nettype wire

// >>> swr_qual_slice.sv
// One qualifier slice: a 256x4 lookup RAM addressed by one data byte.
// Assumes writes come from the bus slave on the same clock.
`default_nettype none
module swr_qual_slice (
    input  wire logic       core_clk,
    input  wire logic       we,
    input  wire logic [7:0] waddr,
    input  wire logic [3:0] wdata,
    input  wire logic [7:0] raddr,
    output logic      [3:0] rdata
);
    import swr_pkg::*;
    // Lookup storage; contents undefined until loaded
    logic [3:0] mem [QUAL_DEPTH];
    // Write port
    always_ff @(posedge core_clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end
    // Asynchronous lookup, as the original static RAM
    assign rdata = mem[raddr];
endmodule
`default_nettype wire

// >>> swr_top.sv
// Sequential word recognizer with independent data qualifier.
// Assumes a byte local bus on core_clk and a data word on the same clock.
// How it works
// - Load mode: step loads pointer from bus
// - Select high: step counts pointer
// - Counting needs control RAM bit zero
// - Steps pass only while gate low
// - Step write advances pointer zero..fifteen
// - Control RAM stores high nibble, inverted
// - Pointer readback in byte bits 5:2
// - Three 4096x1 RAMs, pointer in address
// - Data word supplies other address bits
// - Level match is AND of three
// - Sixteen levels selected by pointer
// - Three 256x4 RAMs addressed by data
// - Qualifier match per bit ANDed
// - Sequence RAM readback port
// - Qualifier RAM readback port
// - Three write ports load one bit each
// - Readback top three bits, reversed
//
// The address-and-strobe port was decided locally.
`default_nettype none
module swr_top (
    input  wire logic              core_clk,
    input  wire logic              reset_n,
    input  wire swr_pkg::swr_bus_t bus,
    output logic      [7:0]        rdata,
    input  wire logic [23:0]       acquired_word,
    output swr_pkg::swr_match_t    match,
    output logic      [3:0]        level_index,
    output logic                   irq
);
    import swr_pkg::*;

    swr_mode_t  mode;              // Pointer mode
    logic       clk_gate_n;        // Active-low step gate
    logic [3:0] ctrl_ram [LEVELS]; // Sequence-control RAM
    logic [3:0] sequence_ctrl_bits; // Inverted control RAM output
    logic       seq_ram [3][SEQ_DEPTH]; // Three level RAMs
    logic [2:0] level_match_bits;  // One bit per level RAM
    logic [3:0] qual_out [3];      // Qualifier slice outputs
    logic [1:0] qual_sel;          // Slice shown on readback
    logic [3:0] qual_rdbk;         // Selected slice nibble
    logic [1:0] irq_stat;          // Sticky level/qual events
    logic [1:0] irq_mask;
    logic [1:0] evt;               // Rising match events
    logic [1:0] evt_prev;
    logic       step;              // Qualified step strobe
    logic       wr_step;

    // Step write hits the pointer only through the gate
    assign wr_step = bus.wr && (bus.addr == STEP_OFS);
    assign step    = wr_step && !clk_gate_n;

    // Mode select from bit 4 of the mode byte
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            mode <= SWR_LOAD;
        end else if (bus.wr && bus.addr == MODE_OFS) begin
            // High leaves load mode, low returns to it
            mode <= bus.wdata[LOAD_SEL_BIT] ? SWR_COUNT : SWR_LOAD;
        end
    end

    // Gate register; writing zero opens the gate
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            clk_gate_n <= GATE_N_RST;
        end else if (bus.wr && bus.addr == GATE_OFS) begin
            clk_gate_n <= bus.wdata[0];
        end
    end

    // Level pointer: load or count on gated step
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            level_index <= PTR_RST;
        end else if (step) begin
            case (mode)
                SWR_LOAD:  level_index <= bus.wdata[3:0];
                SWR_COUNT: begin
                    // Count only when control bit zero asserted
                    if (sequence_ctrl_bits[0]) begin
                        level_index <= level_index + 4'h1;
                    end
                end
                default:   level_index <= level_index;
            endcase
        end
    end

    // Control RAM keeps the upper nibble, addressed by the pointer
    always_ff @(posedge core_clk) begin
        if (bus.wr && bus.addr == CTRL_WR_OFS) begin
            ctrl_ram[level_index] <= bus.wdata[7:4];
        end
    end
    // Outputs invert, so stored zeros read as ones
    assign sequence_ctrl_bits = ~ctrl_ram[level_index];

    // Level RAMs: pointer low four, one data slice high eight
    always_ff @(posedge core_clk) begin
        if (bus.wr && bus.addr == SEQ_WE_A_OFS) begin
            seq_ram[0][{acquired_word[7:0], level_index}] <= bus.wdata[0];
        end
        if (bus.wr && bus.addr == SEQ_WE_B_OFS) begin
            seq_ram[1][{acquired_word[15:8], level_index}] <= bus.wdata[0];
        end
        if (bus.wr && bus.addr == SEQ_WE_C_OFS) begin
            seq_ram[2][{acquired_word[23:16], level_index}] <= bus.wdata[0];
        end
    end
    // Lookups; each slice of the word feeds one RAM
    assign level_match_bits[0] = seq_ram[0][{acquired_word[7:0], level_index}];
    assign level_match_bits[1] = seq_ram[1][{acquired_word[15:8], level_index}];
    assign level_match_bits[2] = seq_ram[2][{acquired_word[23:16], level_index}];

    // Qualifier slices, independent of the pointer
    for (genvar g = 0; g < 3; g++) begin : g_qual
        swr_qual_slice u_slice (
            .core_clk (core_clk),
            .we       (bus.wr && bus.addr == QUAL_WR_A_OFS + 8'(g)),
            .waddr    (acquired_word[8*g +: 8]),
            .wdata    (bus.wdata[3:0]),
            .raddr    (acquired_word[8*g +: 8]),
            .rdata    (qual_out[g])
        );
    end

    // Registered match outputs; data outputs come from flops
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            match <= '0;
        end else begin
            match.level <= &level_match_bits;
            match.qual  <= qual_out[0] & qual_out[1] & qual_out[2];
        end
    end

    // Qualifier readback slice selector
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            qual_sel <= 2'h0;
        end else if (bus.wr && bus.addr == QUAL_SEL_OFS) begin
            qual_sel <= bus.wdata[1:0];
        end
    end

    // Readback mux; the spare fourth code reads as zero, so
    // software never sees an out-of-range slice
    always_comb begin
        case (qual_sel)
            2'h0:    qual_rdbk = qual_out[0]; // Slice A
            2'h1:    qual_rdbk = qual_out[1]; // Slice B
            2'h2:    qual_rdbk = qual_out[2]; // Slice C
            default: qual_rdbk = 4'h0;        // No slice
        endcase
    end

    // Events: rising edges of level and any qualifier match
    assign evt = {|match.qual, match.level} & ~evt_prev;
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            evt_prev <= 2'h0;
        end else begin
            evt_prev <= {|match.qual, match.level};
        end
    end

    // Sticky status, write one to clear; a new event wins
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            irq_stat <= 2'h0;
        end else if (bus.wr && bus.addr == IRQ_STAT_OFS) begin
            irq_stat <= (irq_stat & ~bus.wdata[1:0]) | evt;
        end else begin
            irq_stat <= irq_stat | evt;
        end
    end

    // Interrupt mask
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            irq_mask <= IRQ_MASK_RST;
        end else if (bus.wr && bus.addr == IRQ_MASK_OFS) begin
            irq_mask <= bus.wdata[1:0];
        end
    end
    assign irq = |(irq_stat & irq_mask);

    // Read data, valid in the cycle after the read strobe only
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            rdata <= 8'h00;
        end else if (bus.rd) begin
            case (bus.addr)
                PTR_RDBK_OFS:  rdata <= {2'b00, level_index, 2'b00};
                // Bit order reversed: RAM A lands in bit 7
                SEQ_RDBK_OFS:  rdata <= {level_match_bits[0],
                                         level_match_bits[1],
                                         level_match_bits[2],
                                         5'h00};
                QUAL_RDBK_OFS: rdata <= {4'h0, qual_rdbk};
                CTRL_RD_OFS:   rdata <= {4'h0, sequence_ctrl_bits};
                MODE_OFS:      rdata <= {3'h0, mode == SWR_COUNT, 4'h0};
                GATE_OFS:      rdata <= {7'h00, clk_gate_n};
                IRQ_STAT_OFS:  rdata <= {6'h00, irq_stat};
                IRQ_MASK_OFS:  rdata <= {6'h00, irq_mask};
                default:       rdata <= 8'h00;
            endcase
        end else begin
            rdata <= 8'h00;
        end
    end

    // Counting step moves pointer by exactly one
    a_ptr_count: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        step && mode == SWR_COUNT && sequence_ctrl_bits[0]
        |=> level_index == $past(level_index) + 4'h1)
        else $error("pointer did not count");
    // Load mode copies the low bus nibble
    a_ptr_load: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        step && mode == SWR_LOAD |=> level_index == $past(bus.wdata[3:0]))
        else $error("pointer did not load");
    // Closed gate swallows the step
    a_ptr_hold: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        wr_step && clk_gate_n |=> $stable(level_index))
        else $error("gated step moved pointer");
    // Control bit zero clear freezes the count
    a_ptr_noen: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        step && mode == SWR_COUNT && !sequence_ctrl_bits[0]
        |=> $stable(level_index))
        else $error("pointer counted without enable");
    // Top level rolls over to level zero
    a_ptr_wrap: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        step && mode == SWR_COUNT && sequence_ctrl_bits[0]
        && level_index == 4'hf |=> level_index == 4'h0)
        else $error("pointer did not wrap");

    // Select low returns to load mode
    a_mode_load: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        bus.wr && bus.addr == MODE_OFS && !bus.wdata[LOAD_SEL_BIT]
        |=> mode == SWR_LOAD)
        else $error("mode did not enter load");
    // Select high leaves load mode
    a_mode_count: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        bus.wr && bus.addr == MODE_OFS && bus.wdata[LOAD_SEL_BIT]
        |=> mode == SWR_COUNT)
        else $error("mode did not enter count");
    // Writing zero opens the step gate
    a_gate_open: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        bus.wr && bus.addr == GATE_OFS && !bus.wdata[0] |=> !clk_gate_n)
        else $error("gate did not open");

    // Stored nibble comes back inverted; the write never moves the
    // pointer, so the same cell is still addressed a cycle later
    a_ctrl_write: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        bus.wr && bus.addr == CTRL_WR_OFS
        |=> sequence_ctrl_bits == ~$past(bus.wdata[7:4]))
        else $error("control RAM not inverted");
    // Control readback shows the inverted outputs
    a_ctrl_rdbk: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        bus.rd && bus.addr == CTRL_RD_OFS
        |=> rdata == {4'h0, $past(sequence_ctrl_bits)})
        else $error("control readback wrong");
    // Pointer lands in the middle four bits
    a_ptr_rdbk: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        bus.rd && bus.addr == PTR_RDBK_OFS
        |=> rdata == {2'b00, $past(level_index), 2'b00})
        else $error("pointer readback wrong");

    // All three level RAMs high gives a match; written as
    // implications so unloaded RAM cells stay out of the check
    a_level_hit: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        &level_match_bits |=> match.level)
        else $error("level match missed");
    // A low RAM B output vetoes the match
    a_level_miss: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        !level_match_bits[1] |=> !match.level)
        else $error("level match without RAM B");
    // Write to RAM A lands at the cell now addressed
    a_seq_wr_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        bus.wr && bus.addr == SEQ_WE_A_OFS
        ##1 $stable(acquired_word) && $stable(level_index)
        |-> level_match_bits[0] == $past(bus.wdata[0]))
        else $error("level RAM A write lost");
    // Write to RAM C lands at the cell now addressed
    a_seq_wr_c: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        bus.wr && bus.addr == SEQ_WE_C_OFS
        ##1 $stable(acquired_word) && $stable(level_index)
        |-> level_match_bits[2] == $past(bus.wdata[0]))
        else $error("level RAM C write lost");
    // RAM A shows in bit 7, low five bits stay clear
    a_seq_rdbk: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        bus.rd && bus.addr == SEQ_RDBK_OFS
        |=> rdata[7] == $past(level_match_bits[0]) && rdata[4:0] == 5'h00)
        else $error("sequence readback wrong");
    // RAM C shows in bit 5, reversed from the load order
    a_seq_rdbk_c: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        bus.rd && bus.addr == SEQ_RDBK_OFS
        |=> rdata[5] == $past(level_match_bits[2]))
        else $error("sequence readback order wrong");

    // Bit zero of every slice high gives qualifier zero
    a_qual_hit: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        qual_out[0][0] && qual_out[1][0] && qual_out[2][0]
        |=> match.qual[0])
        else $error("qualifier match missed");
    // A low slice B bit one vetoes qualifier one
    a_qual_miss: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        !qual_out[1][1] |=> !match.qual[1])
        else $error("qualifier match without slice B");
    // Qualifier readback keeps the high nibble clear
    a_qual_rdbk: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        bus.rd && bus.addr == QUAL_RDBK_OFS
        |=> rdata == {4'h0, $past(qual_rdbk)})
        else $error("qualifier readback wrong");

    // Read data stands for one cycle only
    a_rdata_idle: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        !bus.rd |=> rdata == 8'h00)
        else $error("read data outlived its cycle");
    // A match event sets its status bit, even beside a clear
    a_irq_set: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        evt[0] |=> irq_stat[0])
        else $error("level event not latched");
    // Writing one clears a quiet status bit
    a_irq_clear: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        bus.wr && bus.addr == IRQ_STAT_OFS && bus.wdata[0] && !evt[0]
        |=> !irq_stat[0])
        else $error("status bit not cleared");
endmodule
`default_nettype wire

// >>> swr_top_tb_top.sv
// Testbench for the word recognizer: bus tasks and call sequences.
// Assumes the acquisition model and the design on one 25 MHz clock.
`default_nettype none
`define CHK(nm, ex, gt) begin checks_done++; if ((gt) !== (ex)) begin \
    n_mismatch++; $display("unexpected %s exp %h got %h", nm, ex, gt); \
    end end
module swr_top_tb_top;
    import swr_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic       core_clk;        // Bench clock
    logic       reset_n;         // Sync reset
    swr_bus_t   bus;             // Bus request
    logic [7:0] rdata;           // Read data
    logic [23:0] acquired_word;  // Word from model
    swr_match_t match;           // Match results
    logic [3:0] level_index;     // Pointer
    logic       irq;             // Interrupt
    logic       w_load;          // Model load
    logic [23:0] w_in;           // Model word
    int         n_mismatch;      // Mismatches
    int         checks_done;     // Comparisons
    swr_top u_swr_top (.core_clk(core_clk), .reset_n(reset_n), .bus(bus),
        .rdata(rdata), .acquired_word(acquired_word), .match(match),
        .level_index(level_index), .irq(irq));
    swr_acq_model u_swr_acq_model (.core_clk(core_clk), .load(w_load),
        .word_in(w_in), .acquired_word(acquired_word));
    // Clock, 40 ns period
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    // Verdict and end of run
    task automatic test_done();
        $display("mismatches %0d checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // One-cycle write, then idle for a cycle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        bus <= '{default: '0};
        #1;
    endtask
    // Read strobe, data sampled in the following cycle only
    task automatic rdc(input logic [7:0] a, input logic [7:0] ex);
        @(posedge core_clk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        bus <= '{default: '0};
        #1;
        `CHK("rdata", ex, rdata)
    endtask
    // New acquired word through the model
    task automatic set_word(input logic [23:0] w);
        @(posedge core_clk);
        w_load <= 1'b1;
        w_in <= w;
        @(posedge core_clk);
        w_load <= 1'b0;
    endtask
    // Hang guard, well beyond the few hundred cycles of the run
    initial begin
        #400000;
        n_mismatch++;
        test_done();
    end
    // Main sequence
    initial begin
        n_mismatch = 0;
        checks_done = 0;
        bus = '{default: '0};
        w_load = 1'b0;
        w_in = 24'h000000;
        reset_n = 1'b0;
        repeat (5) @(posedge core_clk);
        reset_n <= 1'b1;
        rdc(8'h04, 8'h00);
        rdc(8'h11, 8'h01);
        rdc(8'h10, 8'h00);
        rdc(8'h30, 8'h00);
        `CHK("irq", 1'b0, irq)
        // Gate still closed: step ignored
        wr(8'h12, 8'h09);
        rdc(8'h04, 8'h00);
        wr(8'h11, 8'h00);
        wr(8'h12, 8'h07);
        `CHK("level_index", 4'h7, level_index)
        rdc(8'h04, 8'h1c);
        // Counting check: zeros in control RAM, load zero, count mode
        for (int i = 0; i < 16; i++) begin
            wr(8'h12, 8'(i));
            wr(8'h13, 8'h00);
        end
        wr(8'h12, 8'h00);
        rdc(8'h14, 8'h0f);
        wr(8'h10, 8'h90);
        rdc(8'h10, 8'h10);
        rdc(8'h04, 8'h00);
        for (int i = 1; i <= 16; i++) begin
            wr(8'h12, 8'h00);
            rdc(8'h04, 8'((i % 16) << 2));
        end
        // Bit zero clear stops the count
        wr(8'h10, 8'h80);
        wr(8'h12, 8'h05);
        wr(8'h13, 8'h10);
        rdc(8'h14, 8'h0e);
        wr(8'h10, 8'h90);
        wr(8'h12, 8'h00);
        `CHK("level_index", 4'h5, level_index)
        wr(8'h10, 8'h80);
        // Qualifier slices and per-bit AND
        set_word(24'h332211);
        wr(8'h15, 8'h0f);
        wr(8'h16, 8'h05);
        wr(8'h17, 8'h07);
        @(posedge core_clk);
        #1;
        `CHK("match_qual", 4'h5, match.qual)
        wr(8'h18, 8'h01);
        rdc(8'h07, 8'h05);
        wr(8'h18, 8'h02);
        rdc(8'h07, 8'h07);
        wr(8'h18, 8'h00);
        rdc(8'h07, 8'h0f);
        // Sequence RAM: clear level 4, pattern at level 3
        wr(8'h12, 8'h04);
        for (int k = 0; k < 3; k++) wr(8'(8'h04 + k), 8'h00);
        wr(8'h12, 8'h03);
        wr(8'h04, 8'h01);
        wr(8'h05, 8'h00);
        wr(8'h06, 8'h00);
        rdc(8'h0e, 8'h80);
        `CHK("match_level", 1'b0, match.level)
        wr(8'h19, 8'h03);
        wr(8'h1a, 8'h01);
        rdc(8'h1a, 8'h01);
        wr(8'h05, 8'h01);
        wr(8'h06, 8'h01);
        rdc(8'h0e, 8'he0);
        `CHK("match_level", 1'b1, match.level)
        `CHK("irq", 1'b1, irq)
        rdc(8'h19, 8'h01);
        wr(8'h19, 8'h01);
        `CHK("irq", 1'b0, irq)
        // Other level, then other word: different RAM cells
        wr(8'h12, 8'h04);
        rdc(8'h0e, 8'h00);
        `CHK("match_level", 1'b0, match.level)
        set_word(24'h332212);
        wr(8'h12, 8'h03);
        wr(8'h04, 8'h00);
        rdc(8'h0e, 8'h60);
        `CHK("match_level", 1'b0, match.level)
        test_done();
    end
endmodule
`undef CHK
`default_nettype wire
